// ==== core/csor_map.vh ====
// Address map, field layout and codes of the conversion signal output router.
// Assumes a 12-bit AXI4-Lite byte address space local to the card.
`ifndef CSOR_MAP_VH
`define CSOR_MAP_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CSOR_DRIVE_CFG_ADDR   12'h340
`define CSOR_DRIVE_STAT_ADDR  12'h380

// ----------------------------------------------------------------------------
// Drive configuration fields
// ----------------------------------------------------------------------------
`define CSOR_FIRST_LSB        0
`define CSOR_SECOND_LSB       2
`define CSOR_FRAME_LSB        4
`define CSOR_CFG_BITS         6
`define CSOR_CFG_RESET        6'h00

// ----------------------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------------------
`define CSOR_SEL_REAR         2'h2
`define CSOR_SEL_FRONT        2'h3

// ----------------------------------------------------------------------------
// Front digital lines shared with the generator signals
// ----------------------------------------------------------------------------
`define CSOR_FIRST_LINE       1
`define CSOR_SECOND_LINE      3
`define CSOR_FRAME_LINE       5

// ----------------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------------
`define CSOR_RESP_OKAY        2'h0
`define CSOR_RESP_SLVERR      2'h2

`endif

// ==== core/csor_drive_sel.v ====
// One drive selector: decodes a 2-bit choice for one generator signal.
// Assumes the generator signal is on the same clock as the selector.
`timescale 1ns/1ps
`include "csor_map.vh"

module csor_drive_sel (
  // Selector and generator signal
  input  wire [1:0] sel,
  input  wire       gen,
  // Decoded drive requests
  output wire       rear_o,
  output wire       rear_oe,
  output wire       front_req
);

  // Codes 00 and 01 leave the signal undriven.
  assign rear_oe   = (sel == `CSOR_SEL_REAR);
  assign rear_o    = rear_oe & gen;
  assign front_req = (sel == `CSOR_SEL_FRONT);

endmodule // csor_drive_sel

// ==== core/csor_router.v ====
// Conversion signal output router: AXI4-Lite register and pin drivers.
// Assumes generator signals and the digital output and enable registers
// come from logic on aclk; the pad ring resolves the o and oe pairs.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "csor_map.vh"

module csor_router #(
  parameter ADDR_W  = 12,
  parameter LINES   = 20
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Generator signals
  input  wire              first_rate_gen,
  input  wire              second_rate_gen,
  input  wire              frame_pulse_gen,
  // Digital output registers of the front lines
  input  wire [LINES-1:0]  line_out_value,
  input  wire [LINES-1:0]  line_out_enable,
  // Rear connector pins
  output reg               rear_first_rate_pin_o,
  output reg               rear_first_rate_pin_oe,
  output reg               rear_second_rate_pin_o,
  output reg               rear_second_rate_pin_oe,
  output reg               rear_frame_pulse_pin_o,
  output reg               rear_frame_pulse_pin_oe,
  // Front digital lines
  output reg  [LINES-1:0]  front_digital_line_o,
  output reg  [LINES-1:0]  front_digital_line_oe
);

  // --------------------------------------------------------------------------
  // Drive configuration register
  // --------------------------------------------------------------------------
  reg  [`CSOR_CFG_BITS-1:0] cfg_q;
  reg  [`CSOR_CFG_BITS-1:0] cfg_d;
  wire [1:0] first_rate_drive_select;
  wire [1:0] second_rate_drive_select;
  wire [1:0] frame_pulse_drive_select;

  assign first_rate_drive_select  = cfg_q[`CSOR_FIRST_LSB+1:`CSOR_FIRST_LSB];
  assign second_rate_drive_select = cfg_q[`CSOR_SECOND_LSB+1:`CSOR_SECOND_LSB];
  assign frame_pulse_drive_select = cfg_q[`CSOR_FRAME_LSB+1:`CSOR_FRAME_LSB];

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function [1:0] csor_decode;
    input [ADDR_W-1:0] addr;
    begin
      csor_decode = 2'h0;
      if (addr == `CSOR_DRIVE_CFG_ADDR) begin
        csor_decode = 2'h1;
      end else if (addr == `CSOR_DRIVE_STAT_ADDR) begin
        csor_decode = 2'h2;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  reg  [ADDR_W-1:0] awaddr_q;
  reg               aw_full_q;
  reg               w_full_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  wire              aw_take;
  wire              w_take;
  wire              do_write;
  wire              aw_full_d;
  wire              w_full_d;
  wire              bvalid_d;
  wire [1:0]        wr_hit;

  assign aw_take   = s_axi_awvalid & s_axi_awready;
  assign w_take    = s_axi_wvalid & s_axi_wready;
  assign do_write  = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign aw_full_d = (aw_full_q | aw_take) & ~do_write;
  assign w_full_d  = (w_full_q | w_take) & ~do_write;
  assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_hit    = csor_decode(awaddr_q);

  always @* begin
    cfg_d = cfg_q;
    // Only byte lane 0 holds live bits; the rest of the word is dropped.
    if (do_write && wr_hit == 2'h1 && wstrb_q[0]) begin
      cfg_d = wdata_q[`CSOR_CFG_BITS-1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q         <= `CSOR_CFG_RESET;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CSOR_RESP_OKAY;
    end else begin
      cfg_q         <= cfg_d;
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= ~aw_full_d;
      s_axi_wready  <= ~w_full_d;
      s_axi_bvalid  <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // The status word is read only; a write to it is an error.
      if (do_write) begin
        s_axi_bresp <= (wr_hit == 2'h1) ? `CSOR_RESP_OKAY
                                        : `CSOR_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Selector decode
  // --------------------------------------------------------------------------
  wire [2:0] rear_o_w;
  wire [2:0] rear_oe_w;
  wire [2:0] front_req;

  csor_drive_sel u_first_sel (
    .sel       (first_rate_drive_select),
    .gen       (first_rate_gen),
    .rear_o    (rear_o_w[0]),
    .rear_oe   (rear_oe_w[0]),
    .front_req (front_req[0])
  );

  csor_drive_sel u_second_sel (
    .sel       (second_rate_drive_select),
    .gen       (second_rate_gen),
    .rear_o    (rear_o_w[1]),
    .rear_oe   (rear_oe_w[1]),
    .front_req (front_req[1])
  );

  csor_drive_sel u_frame_sel (
    .sel       (frame_pulse_drive_select),
    .gen       (frame_pulse_gen),
    .rear_o    (rear_o_w[2]),
    .rear_oe   (rear_oe_w[2]),
    .front_req (front_req[2])
  );

  // --------------------------------------------------------------------------
  // Front line merge
  // --------------------------------------------------------------------------
  reg [LINES-1:0] front_o_d;
  reg [LINES-1:0] front_oe_d;
  reg [LINES-1:0] gen_req;
  reg [LINES-1:0] gen_val;
  reg [2:0]       front_gen_live;

  always @* begin
    gen_req = {LINES{1'b0}};
    gen_val = {LINES{1'b0}};
    gen_req[`CSOR_FIRST_LINE]  = front_req[0];
    gen_val[`CSOR_FIRST_LINE]  = first_rate_gen;
    gen_req[`CSOR_SECOND_LINE] = front_req[1];
    gen_val[`CSOR_SECOND_LINE] = second_rate_gen;
    gen_req[`CSOR_FRAME_LINE]  = front_req[2];
    gen_val[`CSOR_FRAME_LINE]  = frame_pulse_gen;
    // Regular digital output wins over any generator selection.
    front_oe_d = line_out_enable | gen_req;
    front_o_d  = (line_out_enable & line_out_value)
               | (~line_out_enable & gen_req & gen_val);
    // A generator reaches its line only while that enable is clear.
    front_gen_live[0] = front_req[0] & ~line_out_enable[`CSOR_FIRST_LINE];
    front_gen_live[1] = front_req[1] & ~line_out_enable[`CSOR_SECOND_LINE];
    front_gen_live[2] = front_req[2] & ~line_out_enable[`CSOR_FRAME_LINE];
  end

  // --------------------------------------------------------------------------
  // Pin registers
  // --------------------------------------------------------------------------
  reg [2:0] front_gen_live_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rear_first_rate_pin_o   <= 1'b0;
      rear_first_rate_pin_oe  <= 1'b0;
      rear_second_rate_pin_o  <= 1'b0;
      rear_second_rate_pin_oe <= 1'b0;
      rear_frame_pulse_pin_o  <= 1'b0;
      rear_frame_pulse_pin_oe <= 1'b0;
      front_digital_line_o    <= {LINES{1'b0}};
      front_digital_line_oe   <= {LINES{1'b0}};
      front_gen_live_q        <= 3'h0;
    end else begin
      rear_first_rate_pin_o   <= rear_o_w[0];
      rear_first_rate_pin_oe  <= rear_oe_w[0];
      rear_second_rate_pin_o  <= rear_o_w[1];
      rear_second_rate_pin_oe <= rear_oe_w[1];
      rear_frame_pulse_pin_o  <= rear_o_w[2];
      rear_frame_pulse_pin_oe <= rear_oe_w[2];
      front_digital_line_o    <= front_o_d;
      front_digital_line_oe   <= front_oe_d;
      front_gen_live_q        <= front_gen_live;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  wire        ar_take;
  wire        rvalid_d;
  wire [1:0]  rd_hit;
  reg  [31:0] rdata_d;

  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign rd_hit   = csor_decode(s_axi_araddr);

  always @* begin
    rdata_d = 32'h0000_0000;
    case (rd_hit)
      2'h1: begin
        rdata_d[`CSOR_CFG_BITS-1:0] = cfg_q;
      end
      2'h2: begin
        rdata_d[2:0] = {rear_frame_pulse_pin_oe, rear_second_rate_pin_oe,
                        rear_first_rate_pin_oe};
        rdata_d[5:3] = front_gen_live_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CSOR_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= (rd_hit == 2'h0) ? `CSOR_RESP_SLVERR
                                        : `CSOR_RESP_OKAY;
      end
    end
  end

endmodule // csor_router

// ==== bench/csor_router_asserts.sv ====
// Checker of the pin drivers and read data of the output router.
// Assumes it is bound into csor_router and sees only its ports.
`timescale 1ns/1ps

module csor_router_asserts #(
  parameter LINES = 20
) (
  input wire             aclk,
  input wire             aresetn,
  input wire             s_axi_rvalid,
  input wire [31:0]      s_axi_rdata,
  input wire             first_rate_gen,
  input wire             second_rate_gen,
  input wire             frame_pulse_gen,
  input wire [LINES-1:0] line_out_value,
  input wire [LINES-1:0] line_out_enable,
  input wire             rear_first_rate_pin_o,
  input wire             rear_first_rate_pin_oe,
  input wire             rear_second_rate_pin_o,
  input wire             rear_second_rate_pin_oe,
  input wire             rear_frame_pulse_pin_o,
  input wire             rear_frame_pulse_pin_oe,
  input wire [LINES-1:0] front_digital_line_o,
  input wire [LINES-1:0] front_digital_line_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_rear_off:
  assert property (!$past(aresetn) |-> !rear_first_rate_pin_oe &&
    !rear_second_rate_pin_oe && !rear_frame_pulse_pin_oe)
    else $error("Rear pin driven right after reset.");
  a_first_rear_echo:
  assert property (rear_first_rate_pin_oe |-> rear_first_rate_pin_o ==
    $past(first_rate_gen) && front_digital_line_oe[1] ==
    $past(line_out_enable[1])) else $error("First rate rear pin wrong.");
  a_second_rear_echo:
  assert property (rear_second_rate_pin_oe |-> rear_second_rate_pin_o ==
    $past(second_rate_gen) && front_digital_line_oe[3] ==
    $past(line_out_enable[3])) else $error("Second rate rear pin wrong.");
  a_frame_rear_echo:
  assert property (rear_frame_pulse_pin_oe |-> rear_frame_pulse_pin_o ==
    $past(frame_pulse_gen) && front_digital_line_oe[5] ==
    $past(line_out_enable[5])) else $error("Frame rear pin wrong.");
  a_first_front_gen:
  assert property ($past(aresetn) && front_digital_line_oe[1] &&
    !$past(line_out_enable[1]) |-> front_digital_line_o[1] ==
    $past(first_rate_gen)) else $error("First rate front line wrong.");
  a_second_front_gen:
  assert property ($past(aresetn) && front_digital_line_oe[3] &&
    !$past(line_out_enable[3]) |-> front_digital_line_o[3] ==
    $past(second_rate_gen)) else $error("Second rate front line wrong.");
  a_frame_front_gen:
  assert property ($past(aresetn) && front_digital_line_oe[5] &&
    !$past(line_out_enable[5]) |-> front_digital_line_o[5] ==
    $past(frame_pulse_gen)) else $error("Frame front line wrong.");
  a_line_out_wins:
  assert property ($past(aresetn) |->
    (~front_digital_line_oe & $past(line_out_enable)) == 0 &&
    ((front_digital_line_o ^ $past(line_out_value)) &
    $past(line_out_enable)) == 0) else $error("Digital output lost.");
  a_reserved_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("Reserved read bits set.");
endmodule // csor_router_asserts

bind csor_router csor_router_asserts #(.LINES(LINES)) i_csor_router_asserts (.*);

// ==== bench/csor_pin_partner.sv ====
// Far-side model: equipment listening on the rear and front lines.
// Assumes a pull-down on every line, so a released line reads low.
`timescale 1ns/1ps

module csor_pin_partner (
  // Rear pins
  input  wire        rear_first_rate_pin_o,
  input  wire        rear_first_rate_pin_oe,
  input  wire        rear_second_rate_pin_o,
  input  wire        rear_second_rate_pin_oe,
  input  wire        rear_frame_pulse_pin_o,
  input  wire        rear_frame_pulse_pin_oe,
  // Front lines
  input  wire [19:0] front_digital_line_o,
  input  wire [19:0] front_digital_line_oe,
  // Levels seen on the far side
  output wire [2:0]  far_rear_level,
  output wire [19:0] far_front_level
);
  assign far_rear_level = {rear_frame_pulse_pin_o & rear_frame_pulse_pin_oe,
    rear_second_rate_pin_o & rear_second_rate_pin_oe,
    rear_first_rate_pin_o & rear_first_rate_pin_oe};
  assign far_front_level = front_digital_line_o & front_digital_line_oe;
endmodule // csor_pin_partner

// ==== bench/tb_top.sv ====
// Self-checking bench of the output router: bus and pin scoreboards.
// Assumes the router top with 12-bit addresses and 20 front lines.
`timescale 1ns/1ps

module tb_top;
  logic        aclk = 0, aresetn = 0, chk = 0, chk2 = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic        first_rate_gen = 0, second_rate_gen = 0, frame_pulse_gen = 0;
  logic [19:0] line_out_value = 0, line_out_enable = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rear_first_rate_pin_o, rear_first_rate_pin_oe;
  wire         rear_second_rate_pin_o, rear_second_rate_pin_oe;
  wire         rear_frame_pulse_pin_o, rear_frame_pulse_pin_oe;
  wire  [19:0] front_digital_line_o, front_digital_line_oe, far_front_level;
  wire  [2:0]  far_rear_level;
  logic [45:0] pin_q[$], pin_e;
  logic [33:0] bus_q[$];
  int          n_errors = 0, num_checks = 0;

  csor_router i_csor_router (.*);
  csor_pin_partner i_csor_pin_partner (.*);

  initial forever #5 aclk = ~aclk;

  task automatic cmp_pins(input logic [45:0] g, input logic [45:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [45:0] pin_exp(logic [5:0] c, logic [2:0] g,
                                          logic [19:0] v, logic [19:0] e);
    logic [19:0] o, oe;
    logic [5:0]  r;
    o = v & e;
    oe = e;
    r = 0;
    for (int k = 0; k < 3; k++) begin
      if (c[2*k+:2] == 2'h2) begin
        r[k+3] = 1'b1;
        r[k] = g[k];
      end
      if (c[2*k+:2] == 2'h3 && !e[2*k+1]) begin
        oe[2*k+1] = 1'b1;
        o[2*k+1] = g[k];
      end
    end
    return {r, oe, o};
  endfunction

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    bus_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
    bus_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask

  task automatic pins(input logic [5:0] c, input int n);
    logic [2:0]  g;
    logic [19:0] v, e;
    repeat (n) begin
      @(posedge aclk);
      g = $urandom;
      v = $urandom;
      e = $urandom & ($urandom % 2 ? 20'hfffff : 20'hfffd5);
      {frame_pulse_gen, second_rate_gen, first_rate_gen} <= g;
      line_out_value <= v;
      line_out_enable <= e;
      chk <= 1'b1;
      pin_q.push_back(pin_exp(c, g, v, e));
    end
    @(posedge aclk);
    chk <= 1'b0;
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge aclk) begin
    chk2 <= chk;
    if (s_axi_rvalid && s_axi_rready)
      cmp_bus({s_axi_rresp, s_axi_rdata}, bus_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus({s_axi_bresp, 32'h0}, bus_q.pop_front());
  end

  always @(negedge aclk) begin
    if (chk2) begin
      pin_e = pin_q.pop_front();
      cmp_pins({rear_frame_pulse_pin_oe, rear_second_rate_pin_oe,
        rear_first_rate_pin_oe, rear_frame_pulse_pin_o, rear_second_rate_pin_o,
        rear_first_rate_pin_o, front_digital_line_oe, front_digital_line_o},
        pin_e);
      // The far side sees a released line at its pull-down level.
      cmp_pins({23'h0, far_rear_level, far_front_level}, {23'h0,
        pin_e[45:43] & pin_e[42:40],
        pin_e[39:20] & pin_e[19:0]});
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up;
  end

  initial begin
    logic [31:0] r;
    void'($urandom(87577));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(12'h340, 34'h0);
    pins(6'h00, 8);
    for (int c = 0; c < 64; c++) begin
      r = $urandom;
      axi_wr(12'h340, {r[31:6], c[5:0]}, 4'hf, 2'h0);
      axi_rd(12'h340, {28'h0, c[5:0]});
      pins(c[5:0], 12);
    end
    axi_wr(12'h340, 32'h2a, 4'he, 2'h0);
    axi_rd(12'h340, {28'h0, 6'h3f});
    axi_wr(12'h100, 32'h15, 4'hf, 2'h2);
    axi_rd(12'h100, {2'h2, 32'h0});
    axi_wr(12'h380, 32'h0, 4'hf, 2'h2);
    axi_rd(12'h340, {28'h0, 6'h3f});
    // Status word: rear drives of first and frame, second on its line.
    line_out_enable <= 20'h0;
    axi_wr(12'h340, 32'h2e, 4'hf, 2'h0);
    axi_rd(12'h380, 34'h15);
    line_out_enable <= 20'h8;
    repeat (2) @(posedge aclk);
    axi_rd(12'h380, 34'h05);
    repeat (4) @(posedge aclk);
    wrap_up;
  end
endmodule // tb_top
